// File: logic/bsc_cond.sv
// Conditioning calculation with clip to a 15-bit fraction
`timescale 1ns/1ns
`default_nettype none
module bsc_cond (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [15:0] adcCount,
    input wire logic [15:0] tempCount,
    input wire logic [15:0] cOff,
    input wire logic [15:0] cGain,
    input wire logic [15:0] cTc1,
    input wire logic [15:0] cTc2,
    input wire logic [15:0] cK2,
    input wire logic [15:0] cK3,
    output logic [14:0] result,
    output logic done
);
    import bsc_pkg::*;
    typedef struct packed {
        logic [14:0] res;
        logic done;
    } bsc_cst_t;
    bsc_cst_t st, next_st;
    logic signed [63:0] x, t, acc;
    // ==========================================================
    // Polynomial evaluation
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        x = 64'($signed(adcCount));
        t = 64'($signed(tempCount));
        // offset, gain, linear and square temperature, square and cube terms
        acc = (64'($signed(cOff)) <<< 15) + 64'($signed(cGain)) * x
            + 64'($signed(cTc1)) * t
            + ((64'($signed(cTc2)) * t) >>> 15) * t
            + ((64'($signed(cK2)) * x) >>> 15) * x
            + ((((64'($signed(cK3)) * x) >>> 15) * x) >>> 15) * x;
        acc = acc >>> 15;
        if (start) begin
            next_st.done = 1'b1;
            if (acc < 64'sd0) begin
                next_st.res = 15'h0000;
            end else if (acc > 64'sd32767) begin
                next_st.res = 15'h7fff;
            end else begin
                next_st.res = acc[14:0];
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
    assign result = st.res;
    assign done = st.done;
endmodule : bsc_cond
`default_nettype wire

// File: logic/bsc_ctrl.sv
// Startup, conversion timing, working modes and register slave
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Resolution 13 or 14 native, 15 or 16 through range zooming.
// - Normal conversion lasts 2^(r+1) clock cycles.
// - High rate conversion lasts two times 2^((r+3)/2) cycles.
// - Converter count uses a stored range shift of 1/16..1/2.
// - Reference select 1 picks analog supply, else bridge supply.
// - Digital result at most 14 bits; analog output 12 bits.
// - Working modes: normal, command, failure signalling.
// - First startup step holds reset, output pin undriven.
// - Second step loads and checks configuration, pin at low range.
// - Third step lasts five conversion times.
// - Third step pin low range or undriven by output mode.
// - Startup error enters failure mode, pin stays low range.
// - After startup conditioning runs and output is enabled unless in software-only mode.
// - Window-then-analog delays analog output until window ends.
// - All durations are fixed clock cycle counts.
// - Correction uses stored coefficients and fixed formulas.
// - Conditioning removes offset, temperature, up to cubic error.
// - Temperature correction has linear and square terms.
// - Result is a non-negative 15-bit fraction readable.
// - Analog value is clipped to programmed output limits.
// - Command entry during startup window by the master command.
// - Failure mode drives low range and reads an error code.
module bsc_ctrl #(
    parameter int PorCyc = bsc_pkg::POR_CYC,
    parameter int CfgCyc = bsc_pkg::CFG_CYC,
    parameter int WinCyc = bsc_pkg::WIN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfgSigOk,
    input wire logic faultIn,
    input wire logic enterCmd,
    input wire logic [15:0] adcCount,
    input wire logic [15:0] tempCount,
    output logic convStart,
    output logic [1:0] resolutionCode,
    output logic highRate,
    output logic [1:0] rangeShift,
    output logic supplyRefSelect,
    output logic aoutOe,
    output logic aoutLdr,
    output logic [11:0] dacCode,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [4:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import bsc_pkg::*;
    typedef struct packed {
        bsc_phase_t phase;
        logic [23:0] tmr;
        logic winOpen;
        logic [2:0] startConv;
        logic convBusy;
        logic [17:0] convCnt;
        logic convStart;
        logic condGo;
        logic [NUM_RW-1:0][31:0] regs;
        logic [14:0] res;
        logic [14:0] clip;
        logic [11:0] dac;
        logic aoutOe;
        logic aoutLdr;
        logic awRdy;
        logic awHave;
        logic [4:0] awAddr;
        logic wRdy;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arRdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bsc_st_t;
    bsc_st_t st, next_st;
    logic [14:0] condRes;
    logic condDone;
    logic [17:0] convLenNow;
    logic [14:0] limLo, limUp;
    bsc_omode_t omode;
    // ==========================================================
    // Conversion time
    // normal or high rate length
    function automatic logic [17:0] conv_len(logic [1:0] rc, logic hr);
        logic [4:0] r;
        logic [4:0] sh;
        r = RES_BASE + {3'h0, rc};
        sh = hr ? (((r + 5'h3) >> 1) + 5'h1) : (r + 5'h1);
        return 18'h1 << sh;
    endfunction : conv_len
    // ==========================================================
    // Byte lane merge
    function automatic logic [31:0] merge(logic [31:0] old,
            logic [31:0] d, logic [3:0] be, logic [31:0] m);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v & m;
    endfunction : merge
    assign omode = bsc_omode_t'(st.regs[0][CTRL_OM +: 2]);
    assign convLenNow = conv_len(st.regs[0][CTRL_RES +: 2],
        st.regs[0][CTRL_HR]);
    assign limLo = st.regs[1][14:0];
    assign limUp = st.regs[1][LIM_UP +: 15];
    // ==========================================================
    // Conditioning unit
    // stored coefficients feed the fixed formula
    bsc_cond bsc_cond_i (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .start(st.condGo),
        .adcCount(adcCount),
        .tempCount(tempCount),
        .cOff(st.regs[2][15:0]),
        .cGain(st.regs[2][31:16]),
        .cTc1(st.regs[3][15:0]),
        .cTc2(st.regs[3][31:16]),
        .cK2(st.regs[4][15:0]),
        .cK3(st.regs[4][31:16]),
        .result(condRes),
        .done(condDone)
    );
    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.convStart = 1'b0;
        next_st.condGo = 1'b0;
        unique case (st.phase)
            PH_POR: begin
                if (st.tmr == 24'(PorCyc - 1)) begin
                    next_st.phase = PH_CFG;
                    next_st.tmr = '0;
                end else begin
                    next_st.tmr = st.tmr + 24'h1;
                end
            end
            PH_CFG: begin
                // configuration check at end of step
                if (st.tmr == 24'(CfgCyc - 1)) begin
                    next_st.tmr = '0;
                    next_st.phase = cfgSigOk ? PH_START : PH_FAIL;
                end else begin
                    next_st.tmr = st.tmr + 24'h1;
                end
            end
            PH_START: begin
                if (st.condGo) begin
                    next_st.startConv = st.startConv + 3'h1;
                    if (st.startConv == START_CONVS - 3'h1) begin
                        next_st.phase = PH_NORMAL;
                        next_st.tmr = '0;
                        next_st.winOpen = (omode == OM_ANALOG_OVR)
                            || (omode == OM_WIN_ANALOG);
                    end
                end
            end
            PH_NORMAL: begin
                if (st.winOpen) begin
                    if (st.tmr == 24'(WinCyc - 1)) begin
                        next_st.winOpen = 1'b0;
                    end else begin
                        next_st.tmr = st.tmr + 24'h1;
                    end
                    if (enterCmd) begin
                        next_st.phase = PH_CMD;
                        next_st.winOpen = 1'b0;
                    end
                end
            end
            PH_CMD: begin
            end
            PH_FAIL: begin
            end
            default: begin
                next_st.phase = PH_FAIL;
            end
        endcase
        if (faultIn && st.phase != PH_POR) begin
            next_st.phase = PH_FAIL;
            next_st.winOpen = 1'b0;
        end
        // Measurement conversions
        if (st.phase == PH_START || st.phase == PH_NORMAL
                || st.phase == PH_CMD) begin
            if (!st.convBusy) begin
                next_st.convBusy = 1'b1;
                next_st.convStart = 1'b1;
                next_st.convCnt = convLenNow - 18'h1;
            end else if (st.convCnt == '0) begin
                next_st.convBusy = 1'b0;
                next_st.condGo = 1'b1;
            end else begin
                next_st.convCnt = st.convCnt - 18'h1;
            end
        end
        if (condDone) begin
            // digital result limited to 14 bits
            next_st.res = condRes & ((st.regs[0][CTRL_RES +: 2] == 2'h0)
                ? DIG_MASK13 : DIG_MASK14);
            if (condRes < limLo) begin
                next_st.clip = limLo;
            end else if (condRes > limUp) begin
                next_st.clip = limUp;
            end else begin
                next_st.clip = condRes;
            end
            next_st.dac = next_st.clip[14:3];
        end
        // AXI write channels
        if (s_axi_awvalid && st.awRdy) begin
            next_st.awHave = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wRdy) begin
            next_st.wHave = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.awHave && st.wHave && !st.bvalid) begin
            next_st.awHave = 1'b0;
            next_st.wHave = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            unique case ({st.awAddr[4:2], 2'h0})
                ADDR_CTRL: begin
                    next_st.regs[0] = merge(st.regs[0], st.wData,
                        st.wStrb, CTRL_MASK);
                    if (st.wStrb[1] && st.wData[CTRL_CMDX]
                            && st.phase == PH_CMD
                            && next_st.phase == PH_CMD) begin
                        next_st.phase = PH_NORMAL;
                    end
                end
                ADDR_LIMIT: begin
                    next_st.regs[1] = merge(st.regs[1], st.wData,
                        st.wStrb, LIMIT_MASK);
                end
                ADDR_COEF0, ADDR_COEF1, ADDR_COEF2: begin
                    next_st.regs[st.awAddr[4:2]] = merge(
                        st.regs[st.awAddr[4:2]], st.wData, st.wStrb,
                        COEF_MASK);
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        // AXI read channel
        if (s_axi_rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arRdy) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = '0;
            unique case ({s_axi_araddr[4:2], 2'h0})
                ADDR_CTRL, ADDR_LIMIT, ADDR_COEF0, ADDR_COEF1,
                ADDR_COEF2: begin
                    next_st.rdata = st.regs[s_axi_araddr[4:2]];
                end
                ADDR_STATUS: begin
                    next_st.rdata = {28'h0, st.winOpen, st.phase};
                end
                ADDR_RESULT: begin
                    next_st.rdata = (st.phase == PH_FAIL)
                        ? {16'h0, ERR_CODE} : {17'h0, st.res};
                end
                default: begin
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.awRdy = !next_st.awHave && !next_st.bvalid;
        next_st.wRdy = !next_st.wHave && !next_st.bvalid;
        next_st.arRdy = !next_st.rvalid;
        // Output pin drive from the coming phase
        next_st.aoutOe = 1'b0;
        next_st.aoutLdr = 1'b0;
        unique case (next_st.phase)
            PH_POR, PH_CMD: begin
            end
            PH_CFG, PH_FAIL: begin
                next_st.aoutOe = 1'b1;
                next_st.aoutLdr = 1'b1;
            end
            PH_START: begin
                next_st.aoutOe = (omode == OM_ANALOG_OVR)
                    || (omode == OM_SW_DIS);
                next_st.aoutLdr = next_st.aoutOe;
            end
            PH_NORMAL: begin
                // analog held back during the window in window-then-analog mode
                next_st.aoutOe = (omode != OM_SW_ONLY)
                    && !(omode == OM_WIN_ANALOG && next_st.winOpen);
            end
            default: begin
                next_st.aoutOe = 1'b1;
                next_st.aoutLdr = 1'b1;
            end
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.phase <= PH_POR;
            st.regs <= {COEF_RST, COEF_RST, COEF0_RST, LIMIT_RST,
                CTRL_RST};
        end else if (ce) begin
            st <= next_st;
        end
    end
    // ==========================================================
    // Outputs
    assign convStart = st.convStart;
    assign resolutionCode = st.regs[0][CTRL_RES +: 2];
    assign highRate = st.regs[0][CTRL_HR];
    assign rangeShift = st.regs[0][CTRL_RS +: 2];
    assign supplyRefSelect = st.regs[0][CTRL_REF];
    assign aoutOe = st.aoutOe;
    assign aoutLdr = st.aoutLdr;
    assign dacCode = st.dac;
    assign s_axi_awready = st.awRdy;
    assign s_axi_wready = st.wRdy;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arRdy;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    // ==========================================================
    // Assertions
    a_por_undriven: assert property (
        @(posedge mclk) disable iff (rst)
        st.phase == PH_POR |-> !aoutOe)
        else $error("pin driven during reset settling");
    a_cfg_low_range: assert property (
        @(posedge mclk) disable iff (rst)
        st.phase == PH_CFG |-> aoutOe && aoutLdr)
        else $error("pin not low range during config");
    a_start_pin_mode: assert property (
        @(posedge mclk) disable iff (rst)
        st.phase == PH_START |-> aoutOe == ((omode == OM_ANALOG_OVR)
            || (omode == OM_SW_DIS)))
        else $error("start routine pin drive wrong");
    a_fail_low_range: assert property (
        @(posedge mclk) disable iff (rst)
        st.phase == PH_FAIL |-> aoutOe && aoutLdr)
        else $error("failure mode not at low range");
    a_step_order: assert property (
        @(posedge mclk) disable iff (rst)
        $changed(st.phase) && st.phase == PH_START
            |-> $past(st.phase) == PH_CFG)
        else $error("start routine entered out of order");
    a_conv_length: assert property (
        @(posedge mclk) disable iff (rst)
        convStart |-> st.convCnt == $past(convLenNow) - 18'h1)
        else $error("conversion length wrong");
    a_conv_gap: assert property (
        @(posedge mclk) disable iff (rst)
        convStart && ce && st.phase != PH_FAIL
            && !faultIn |=> !convStart)
        else $error("conversion restarted too soon");
    a_clip_limits: assert property (
        @(posedge mclk) disable iff (rst)
        condDone && ce && limLo <= limUp
            |=> st.clip >= limLo && st.clip <= limUp)
        else $error("clipped value outside limits");
    a_win_delay: assert property (
        @(posedge mclk) disable iff (rst)
        st.phase == PH_NORMAL && omode == OM_WIN_ANALOG && st.winOpen
            |-> !aoutOe)
        else $error("analog output during window");
    a_cmd_entry: assert property (
        @(posedge mclk) disable iff (rst)
        ce && enterCmd && st.winOpen && st.phase == PH_NORMAL
            && !faultIn |=> st.phase == PH_CMD)
        else $error("command entry missed");
endmodule : bsc_ctrl
`default_nettype wire

// File: logic/bsc_pkg.sv
// Constants and types of the bridge sensor conditioning control
package bsc_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_NS = 40;
    localparam int T_POR_NS = 500000;
    localparam int T_CFG_NS = 200000;
    localparam int T_WIN_NS = 500000000;
    localparam int POR_CYC = (T_POR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CFG_CYC = (T_CFG_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC = T_WIN_NS / CLK_NS;
    localparam logic [2:0] START_CONVS = 3'h5;
    localparam logic [4:0] RES_BASE = 5'hd;
    // ==========================================================
    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_LIMIT = 5'h04;
    localparam logic [4:0] ADDR_COEF0 = 5'h08;
    localparam logic [4:0] ADDR_COEF1 = 5'h0c;
    localparam logic [4:0] ADDR_COEF2 = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_RESULT = 5'h18;
    localparam int NUM_RW = 5;
    // ==========================================================
    // Control and limit fields
    localparam int CTRL_RES = 0;
    localparam int CTRL_HR = 2;
    localparam int CTRL_RS = 3;
    localparam int CTRL_REF = 5;
    localparam int CTRL_OM = 6;
    localparam int CTRL_CMDX = 8;
    localparam int LIM_UP = 16;
    // ==========================================================
    // Reset values and masks
    localparam logic [31:0] CTRL_RST = 32'h00000001;
    localparam logic [31:0] LIMIT_RST = 32'h7fff0000;
    localparam logic [31:0] COEF0_RST = 32'h7fff0000;
    localparam logic [31:0] COEF_RST = 32'h00000000;
    localparam logic [31:0] CTRL_MASK = 32'h000000ff;
    localparam logic [31:0] LIMIT_MASK = 32'h7fff7fff;
    localparam logic [31:0] COEF_MASK = 32'hffffffff;
    localparam logic [15:0] ERR_CODE = 16'hffff;
    localparam logic [14:0] DIG_MASK13 = 15'h7ffc;
    localparam logic [14:0] DIG_MASK14 = 15'h7ffe;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Phases and output modes
    typedef enum logic [2:0] {
        PH_POR, PH_CFG, PH_START, PH_NORMAL, PH_CMD, PH_FAIL
    } bsc_phase_t;
    typedef enum logic [1:0] {
        OM_ANALOG_OVR, OM_SW_DIS, OM_WIN_ANALOG, OM_SW_ONLY
    } bsc_omode_t;
endpackage : bsc_pkg

// File: sim/testbench.sv
// Self-checking bench of the conditioning control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import bsc_pkg::*;
    logic mclk, rst, ce, cfgSigOk, faultIn, enterCmd;
    logic [15:0] adcCount, tempCount;
    logic convStart, highRate, supplyRefSelect, aoutOe, aoutLdr;
    logic [1:0] resolutionCode, rangeShift, bresp, rresp;
    logic [11:0] dacCode;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] rs;
    int badCount = 0;
    int nChecks = 0;
    int cyc = 0;
    bsc_ctrl #(.PorCyc(20), .CfgCyc(20), .WinCyc(50)) bsc_ctrl_i (
        .mclk(mclk), .rst(rst), .ce(ce), .cfgSigOk(cfgSigOk),
        .faultIn(faultIn), .enterCmd(enterCmd), .adcCount(adcCount),
        .tempCount(tempCount), .convStart(convStart),
        .resolutionCode(resolutionCode), .highRate(highRate),
        .rangeShift(rangeShift), .supplyRefSelect(supplyRefSelect),
        .aoutOe(aoutOe), .aoutLdr(aoutLdr), .dacCode(dacCode),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    // ==========================================================
    // Common tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        logic pa, pw, b, ta, tw;
        pa = 1; pw = 1; b = 0;
        @(posedge mclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!b) begin
            @(negedge mclk);
            ta = pa && awready; tw = pw && wready; b = bvalid; rs = bresp;
            @(posedge mclk);
            if (ta) begin awvalid <= 0; pa = 0; end
            if (tw) begin wvalid <= 0; pw = 0; end
        end
        bready <= 0;
    endtask : axw
    task automatic axr(input logic [4:0] a);
        logic pa, b, ta;
        pa = 1; b = 0;
        @(posedge mclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!b) begin
            @(negedge mclk);
            ta = pa && arready; b = rvalid; rd = rdata; rs = rresp;
            @(posedge mclk);
            if (ta) begin arvalid <= 0; pa = 0; end
        end
        rready <= 0;
    endtask : axr
    task automatic per(input int e);
        int n;
        @(negedge mclk);
        while (!convStart) @(negedge mclk);
        n = 0;
        do begin @(negedge mclk); n++; end while (!convStart);
        chk(n, e);
    endtask : per
    // ==========================================================
    // Scenarios
    task automatic t_startup;
        int n;
        @(negedge mclk);
        chk(aoutOe, 0);
        axw(ADDR_CTRL, 32'h00000044);
        chk(rs, RESP_OKAY);
        while (!aoutOe) @(negedge mclk);
        chk(aoutLdr, 1);
        n = 0;
        while (aoutLdr) begin
            @(negedge mclk);
            n += convStart && aoutLdr;
        end
        chk(n, 5);
        chk(aoutOe, 1);
        axr(ADDR_STATUS);
        chk(rd[2:0], 3);
    endtask : t_startup
    task automatic t_regs;
        axw(ADDR_CTRL, 32'h0000002d);
        @(negedge mclk);
        chk({resolutionCode, highRate, rangeShift}, 5'h0d);
        chk(supplyRefSelect, 1);
        axr(ADDR_CTRL);
        chk(rd, 32'h0000002d);
        axw(ADDR_CTRL, 32'h00000000);
        per(16385);
        axw(ADDR_CTRL, 32'h00000006);
        per(1025);
    endtask : t_regs
    task automatic t_clip;
        axw(ADDR_LIMIT, 32'h10001000);
        per(1025);
        repeat (3) @(negedge mclk);
        chk(dacCode, 12'h200);
        axr(ADDR_RESULT);
        chk(rd >> 15, 0);
        axw(ADDR_STATUS, 32'h00000001);
        chk(rs, RESP_SLVERR);
        axr(5'h1c);
        chk(rs, RESP_SLVERR);
    endtask : t_clip
    task automatic t_fail;
        faultIn <= 1;
        repeat (3) @(negedge mclk);
        chk({aoutOe, aoutLdr}, 2'h3);
        faultIn <= 0;
        axr(ADDR_STATUS);
        chk(rd[2:0], 5);
        axr(ADDR_RESULT);
        chk(rd[15:0], ERR_CODE);
    endtask : t_fail
    task automatic t_cmd;
        rst <= 1;
        repeat (2) @(posedge mclk);
        rst <= 0;
        axw(ADDR_CTRL, 32'h00000084);
        chk(rs, RESP_OKAY);
        while (!aoutLdr) @(negedge mclk);
        while (aoutLdr) @(negedge mclk);
        chk(aoutOe, 0);
        do axr(ADDR_STATUS); while (rd[2:0] != 3);
        chk(rd[3], 1);
        @(negedge mclk);
        chk(aoutOe, 0);
        @(posedge mclk);
        enterCmd <= 1;
        @(posedge mclk);
        enterCmd <= 0;
        axr(ADDR_STATUS);
        chk(rd[2:0], 4);
        chk(aoutOe, 0);
        axw(ADDR_CTRL, 32'h00000184);
        axr(ADDR_STATUS);
        chk(rd[2:0], 3);
        @(negedge mclk);
        chk(aoutOe, 1);
    endtask : t_cmd
    // ==========================================================
    // Clock, timeout and main sequence
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            badCount++;
            finish_test();
        end
    end
    initial begin
        rst = 1; ce = 1; cfgSigOk = 1; faultIn = 0; enterCmd = 0;
        adcCount = 16'h1000; tempCount = 16'h0000;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 5'h00; araddr = 5'h00; wdata = 32'h0;
        repeat (12) @(posedge mclk);
        rst <= 0;
        t_startup();
        t_regs();
        t_clip();
        t_fail();
        t_cmd();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
